// [core/gpcr_pkg.sv]
// gpcr_pkg: register map, reset values and encodings of the pad control slice
package gpcr_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned GPCR_PINS     = 16;
  localparam int unsigned GPCR_ADDR_W   = 6;
  localparam int unsigned GPCR_DATA_W   = 32;
  localparam int unsigned GPCR_FIELD_W  = 2;
  localparam int unsigned GPCR_SYNC_STG = 2;

  // ****************************************************************
  // byte offsets on the bus
  // ****************************************************************
  localparam logic [5:0] GPCR_OFS_DRIVE  = 6'h08;
  localparam logic [5:0] GPCR_OFS_PULL   = 6'h0c;
  localparam logic [5:0] GPCR_OFS_INPUT  = 6'h10;
  localparam logic [5:0] GPCR_OFS_OUTPUT = 6'h14;
  localparam logic [5:0] GPCR_OFS_STROBE = 6'h18;
  localparam logic [5:0] GPCR_OFS_FREEZE = 6'h1c;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] GPCR_RST_DRIVE_A = 32'h0c000000;
  localparam logic [31:0] GPCR_RST_PULL_A  = 32'h24000000;
  localparam logic [31:0] GPCR_RST_ZERO    = 32'h00000000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned GPCR_KEY_BIT   = 16;
  localparam int unsigned GPCR_CLR_BASE  = 16;
  localparam int unsigned GPCR_READ_WAIT = 1;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0] GPCR_PULL_NONE = 2'h0;
  localparam logic [1:0] GPCR_PULL_UP   = 2'h1;
  localparam logic [1:0] GPCR_PULL_DOWN = 2'h2;
  localparam logic [1:0] GPCR_PULL_RSVD = 2'h3;

  typedef enum logic [1:0] {
    GPCR_SPD_2M  = 2'h0,
    GPCR_SPD_10M = 2'h1,
    GPCR_SPD_50M = 2'h2
  } gpcr_speed_t;

  typedef enum logic [2:0] {
    GPCR_KEY_IDLE = 3'h0,
    GPCR_KEY_W1   = 3'h1,
    GPCR_KEY_W0   = 3'h3,
    GPCR_KEY_W1B  = 3'h2,
    GPCR_KEY_ARM  = 3'h6
  } gpcr_key_state_t;

endpackage : gpcr_pkg

// [core/gpcr_sync_if.sv]
// gpcr_sync_if: carries raw pin levels in and synchronised levels out
`timescale 1ns/1ps
`default_nettype none
interface gpcr_sync_if #(
  parameter int unsigned WIDTH = 16
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;

  modport user (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : gpcr_sync_if
`default_nettype wire

// [core/gpcr_sync.sv]
// gpcr_sync: two-stage synchroniser for the asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpcr_sync
  import gpcr_pkg::*;
#(
  parameter int unsigned WIDTH = GPCR_PINS
) (
  // clock and reset
  input  wire logic   mclk,
  input  wire logic   rst_n,
  // levels
  gpcr_sync_if.sync   lv
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // the first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= lv.raw;
      sync_q <= meta_q;
    end
  end

  assign lv.synced = sync_q;

endmodule : gpcr_sync
`default_nettype wire

// [core/gpcr_top.sv]
// gpcr_top: gpio pad control register slice with avalon-mm slave
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpcr_top
  import gpcr_pkg::*;
#(
  parameter bit IS_PORT_A = 1'b1,
  parameter bit HAS_LOCK  = 1'b1
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // avalon-mm slave
  input  wire logic [GPCR_ADDR_W-1:0]    avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [GPCR_DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [GPCR_DATA_W-1:0]    avs_readdata,
  output logic                           avs_waitrequest,
  // pins and neighbouring configuration
  input  wire logic [GPCR_PINS-1:0]      pin_level,
  input  wire logic [GPCR_PINS-1:0]      pin_analog_mode,
  input  wire logic [GPCR_PINS-1:0]      very_high_speed_bit,
  // pad controls
  output logic      [2*GPCR_PINS-1:0]    pad_drive_speed,
  output logic      [2*GPCR_PINS-1:0]    pad_speed_class,
  output logic      [GPCR_PINS-1:0]      pad_very_high_speed,
  output logic      [2*GPCR_PINS-1:0]    pad_pull_select,
  output logic      [GPCR_PINS-1:0]      pad_output_level,
  output logic      [GPCR_PINS-1:0]      pin_config_frozen
);

  localparam int unsigned NP = GPCR_PINS;

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  gpcr_sync_if #(.WIDTH(NP)) lv_if ();

  assign lv_if.raw = pin_level;

  gpcr_sync #(
    .WIDTH (NP)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .lv    (lv_if.sync)
  );

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // waitrequest idles high; one low cycle answers each request, so a
  // request is accepted exactly at the edge that sees it low
  logic                   wait_q;
  logic [GPCR_DATA_W-1:0] rdata_q;
  logic                   req;
  logic                   acc;
  logic                   wr_acc;
  logic                   rd_acc;
  logic [GPCR_DATA_W-1:0] be_mask;
  logic [5:0]             ofs;

  assign req    = avs_read | avs_write;
  assign acc    = req & !wait_q;
  assign wr_acc = acc & avs_write;
  assign rd_acc = acc & avs_read;
  assign ofs    = {avs_address[GPCR_ADDR_W-1:2], 2'h0};
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [2*NP-1:0]  drive_q;
  logic [2*NP-1:0]  pull_q;
  logic [NP-1:0]    in_lvl_q;
  logic [NP-1:0]    out_lvl_q;
  logic [NP-1:0]    lock_bits_q;
  logic             key_q;
  gpcr_key_state_t  key_st_q;
  logic [NP-1:0]    frozen;

  // pins only freeze once the key has been engaged
  assign frozen = key_q ? lock_bits_q : '0;

  logic [2*NP-1:0] drive_wr;
  logic [2*NP-1:0] pull_wr;

  // per-pin field merge honours byte lanes and the freeze
  for (genvar p = 0; p < NP; p++) begin : g_pin
    logic [1:0] dv_new;
    logic [1:0] pl_new;
    logic [1:0] msk;

    assign msk    = be_mask[2*p +: 2];
    assign dv_new = (avs_writedata[2*p +: 2] & msk)
                  | (drive_q[2*p +: 2] & ~msk);
    assign pl_new = (avs_writedata[2*p +: 2] & msk)
                  | (pull_q[2*p +: 2] & ~msk);
    assign drive_wr[2*p +: 2] = frozen[p] ? drive_q[2*p +: 2]
                                          : dv_new;
    // the reserved pull code is never stored
    assign pull_wr[2*p +: 2] = (frozen[p] || pl_new == GPCR_PULL_RSVD)
                             ? pull_q[2*p +: 2] : pl_new;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      drive_q <= IS_PORT_A ? GPCR_RST_DRIVE_A : GPCR_RST_ZERO;
    end else if (wr_acc && ofs == GPCR_OFS_DRIVE) begin
      drive_q <= drive_wr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pull_q <= IS_PORT_A ? GPCR_RST_PULL_A : GPCR_RST_ZERO;
    end else if (wr_acc && ofs == GPCR_OFS_PULL) begin
      pull_q <= pull_wr;
    end
  end

  // sampled every cycle; analog pins read as low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      in_lvl_q <= '0;
    end else begin
      in_lvl_q <= lv_if.synced & ~pin_analog_mode;
    end
  end

  // ****************************************************************
  // output level and set/clear strobe
  // ****************************************************************
  logic [NP-1:0] set_str;
  logic [NP-1:0] clr_str;

  assign set_str = avs_writedata[NP-1:0] & be_mask[NP-1:0];
  assign clr_str = avs_writedata[GPCR_CLR_BASE +: NP]
                 & be_mask[GPCR_CLR_BASE +: NP];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_lvl_q <= GPCR_RST_ZERO[NP-1:0];
    end else if (wr_acc && ofs == GPCR_OFS_OUTPUT) begin
      out_lvl_q <= (avs_writedata[NP-1:0] & be_mask[NP-1:0])
                 | (out_lvl_q & ~be_mask[NP-1:0]);
    end else if (wr_acc && ofs == GPCR_OFS_STROBE) begin
      // set applied after clear so it wins on the same pin
      out_lvl_q <= (out_lvl_q & ~clr_str) | set_str;
    end
  end

  // ****************************************************************
  // freeze register and key sequence
  // ****************************************************************
  logic lk_wr;
  logic lk_rd;
  logic lk_full;
  logic lk_same;
  logic lk_kv;

  assign lk_wr   = HAS_LOCK && wr_acc && ofs == GPCR_OFS_FREEZE && !key_q;
  assign lk_rd   = HAS_LOCK && rd_acc && ofs == GPCR_OFS_FREEZE && !key_q;
  // a key write must carry the key lane and both pin lanes
  assign lk_full = &avs_byteenable[2:0];
  assign lk_same = avs_writedata[NP-1:0] == lock_bits_q;
  assign lk_kv   = avs_writedata[GPCR_KEY_BIT];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lock_bits_q <= GPCR_RST_ZERO[NP-1:0];
    end else if (lk_wr) begin
      lock_bits_q <= (avs_writedata[NP-1:0] & be_mask[NP-1:0])
                   | (lock_bits_q & ~be_mask[NP-1:0]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      key_st_q <= GPCR_KEY_IDLE;
    end else if (lk_wr) begin
      unique case (key_st_q)
        GPCR_KEY_W1: begin
          key_st_q <= (lk_full && lk_same && !lk_kv) ? GPCR_KEY_W0
                    : (lk_full && lk_kv) ? GPCR_KEY_W1
                    : GPCR_KEY_IDLE;
        end
        GPCR_KEY_W0: begin
          key_st_q <= (lk_full && lk_same && lk_kv) ? GPCR_KEY_W1B
                    : GPCR_KEY_IDLE;
        end
        // any write outside the expected step restarts the sequence
        default: begin
          key_st_q <= (lk_full && lk_kv) ? GPCR_KEY_W1
                    : GPCR_KEY_IDLE;
        end
      endcase
    end else if (lk_rd) begin
      unique case (key_st_q)
        GPCR_KEY_W1B: key_st_q <= GPCR_KEY_ARM;
        default:      key_st_q <= GPCR_KEY_IDLE;
      endcase
    end
  end

  // the read that sees key 0 after write-1-0-1 engages it; the next
  // read returns 1 and nothing but reset clears it again
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      key_q <= 1'b0;
    end else if (lk_rd && key_st_q == GPCR_KEY_W1B) begin
      key_q <= 1'b1;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [GPCR_DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (ofs)
      GPCR_OFS_DRIVE:  rd_mux = drive_q;
      GPCR_OFS_PULL:   rd_mux = pull_q;
      GPCR_OFS_INPUT:  rd_mux = {{(GPCR_DATA_W-NP){1'b0}}, in_lvl_q};
      GPCR_OFS_OUTPUT: rd_mux = {{(GPCR_DATA_W-NP){1'b0}}, out_lvl_q};
      GPCR_OFS_FREEZE: begin
        if (HAS_LOCK) begin
          rd_mux = {{(GPCR_DATA_W-NP-1){1'b0}}, key_q, lock_bits_q};
        end
      end
      default:         rd_mux = '0;
    endcase
  end

  // captured on the edge that drops waitrequest, so it stands with it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (avs_read && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  // ****************************************************************
  // pad drive
  // ****************************************************************
  logic [2*NP-1:0] spd_cls_q;
  logic [NP-1:0]   vhs_q;
  logic [NP-1:0]   frozen_q;

  function automatic gpcr_speed_t speed_of(input logic [1:0] f);
    if (!f[0]) begin
      return GPCR_SPD_2M;
    end
    return f[1] ? GPCR_SPD_50M : GPCR_SPD_10M;
  endfunction : speed_of

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      spd_cls_q <= '0;
      vhs_q     <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        spd_cls_q[2*p +: 2] <= speed_of(drive_q[2*p +: 2]);
        vhs_q[p] <= (&drive_q[2*p +: 2]) & very_high_speed_bit[p];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      frozen_q <= '0;
    end else begin
      frozen_q <= frozen;
    end
  end

  assign pad_drive_speed     = drive_q;
  assign pad_speed_class     = spd_cls_q;
  assign pad_very_high_speed = vhs_q;
  assign pad_pull_select     = pull_q;
  assign pad_output_level    = out_lvl_q;
  assign pin_config_frozen   = frozen_q;

endmodule : gpcr_top
`default_nettype wire

// [sim/gpcr_assertions.sv]
// gpcr_assertions: bus, register and freeze checks on gpcr_top ports
`timescale 1ns/1ps
`default_nettype none
module gpcr_assertions
  import gpcr_pkg::*;
#(
  parameter bit IS_PORT_A = 1'b1
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pads
  input wire logic [31:0] pad_drive_speed,
  input wire logic [31:0] pad_speed_class,
  input wire logic [31:0] pad_pull_select,
  input wire logic [15:0] pad_output_level,
  input wire logic [15:0] pin_config_frozen
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  function automatic logic [31:0] cls(logic [31:0] d);
    for (int i = 0; i < 16; i++)
      cls[2*i+:2] = !d[2*i] ? 2'h0 : (d[2*i+1] ? 2'h2 : 2'h1);
  endfunction : cls

  function automatic logic [31:0] wide(logic [15:0] f);
    for (int i = 0; i < 16; i++)
      wide[2*i+:2] = {2{f[i]}};
  endfunction : wide

  sequence acc_s;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  sequence strobe_s;
    acc_s ##0 avs_write && avs_address[5:2] == 4'h6 && avs_byteenable == 4'hf;
  endsequence

  speed_class_a: assert property ($past(rst_n) |->
    pad_speed_class == cls($past(pad_drive_speed)))
    else $error("speed class wrong");
  pull_rsvd_a: assert property (
    (pad_pull_select & (pad_pull_select >> 1) & 32'h55555555) == 32'h0)
    else $error("reserved pull code stored");
  reset_vals_a: assert property ($rose(rst_n) |->
    pad_drive_speed == (IS_PORT_A ? GPCR_RST_DRIVE_A : 32'h0) &&
    pad_pull_select == (IS_PORT_A ? GPCR_RST_PULL_A : 32'h0))
    else $error("config reset value wrong");
  reset_out_a: assert property ($rose(rst_n) |->
    pad_output_level == 16'h0 && pin_config_frozen == 16'h0)
    else $error("output or freeze reset value wrong");
  frozen_keep_a: assert property ($past(rst_n) |->
    (((pad_drive_speed ^ $past(pad_drive_speed)) |
      (pad_pull_select ^ $past(pad_pull_select)))
     & wide($past(pin_config_frozen))) == 32'h0)
    else $error("frozen pin field changed");
  frozen_hold_a: assert property (
    $past(rst_n) && $past(pin_config_frozen) != 16'h0
    |-> $stable(pin_config_frozen))
    else $error("freeze released without reset");
  strobe_out_a: assert property (strobe_s |=>
    pad_output_level == (($past(pad_output_level) &
    ~$past(avs_writedata[31:16])) | $past(avs_writedata[15:0])))
    else $error("strobe result wrong");
  read_top_a: assert property (
    acc_s ##0 avs_read && avs_address[5:2] == 4'h4
    |-> avs_readdata[31:16] == 16'h0)
    else $error("input level upper half not zero");
  wait_single_a: assert property (acc_s |=> avs_waitrequest)
    else $error("wait low for more than one cycle");
  wait_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("request not answered");
endmodule : gpcr_assertions
`default_nettype wire

// [sim/gpcr_pin_model.sv]
// gpcr_pin_model: external pins, driven by the pad or an outside source
`timescale 1ns/1ps
`default_nettype none
module gpcr_pin_model (
  // pad side
  input  wire logic [15:0] pad_output_level,
  // outside source
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  // pin side
  output logic      [15:0] pin_level
);
  // an outside source overrides the pad driver
  assign pin_level = (ext_en & ext_val) | (~ext_en & pad_output_level);
endmodule : gpcr_pin_model
`default_nettype wire

// [sim/test_gpcr_top.sv]
// test_gpcr_top: self-checking bench of the pad control slice
`timescale 1ns/1ps
`default_nettype none
bind gpcr_top gpcr_assertions #(.IS_PORT_A(IS_PORT_A)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pad_drive_speed(pad_drive_speed), .pad_speed_class(pad_speed_class),
  .pad_pull_select(pad_pull_select), .pad_output_level(pad_output_level),
  .pin_config_frozen(pin_config_frozen));
module test_gpcr_top;
  import gpcr_pkg::*;
  // ****************
  // signals
  // ****************
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [15:0] pin_level, pin_analog_mode, very_high_speed_bit;
  logic [15:0] ext_en, ext_val, pad_very_high_speed;
  logic [15:0] pad_output_level, pin_config_frozen;
  logic [31:0] pad_drive_speed, pad_speed_class, pad_pull_select;
  logic [31:0] b_drive, b_pull;
  logic [15:0] b_frozen;
  int          failures, num_checks;
  typedef struct packed {
    logic wr; logic [5:0] adr; logic [31:0] dat; logic [3:0] be;
    logic [31:0] exp;
  } gpcr_row_t;
  gpcr_row_t rows [25] = '{
    '{1'b0, 6'h08, 32'h0, 4'hf, 32'h0c000000},
    '{1'b0, 6'h0c, 32'h0, 4'hf, 32'h24000000},
    '{1'b0, 6'h14, 32'h0, 4'hf, 32'h0},
    '{1'b0, 6'h1c, 32'h0, 4'hf, 32'h0},
    '{1'b0, 6'h00, 32'h0, 4'hf, 32'h0},
    '{1'b1, 6'h08, 32'hffffffff, 4'hf, 32'h0},
    '{1'b0, 6'h08, 32'h0, 4'hf, 32'hffffffff},
    '{1'b1, 6'h0c, 32'h99999999, 4'hf, 32'h0},
    '{1'b0, 6'h0c, 32'h0, 4'hf, 32'h99999999},
    '{1'b1, 6'h0c, 32'hffffffff, 4'hf, 32'h0},
    '{1'b0, 6'h0c, 32'h0, 4'hf, 32'h99999999},
    '{1'b1, 6'h14, 32'hffffa5a5, 4'h1, 32'h0},
    '{1'b0, 6'h14, 32'h0, 4'hf, 32'h000000a5},
    '{1'b1, 6'h14, 32'h00005a00, 4'h2, 32'h0},
    '{1'b0, 6'h14, 32'h0, 4'hf, 32'h00005aa5},
    '{1'b1, 6'h18, 32'h00ff0f00, 4'hf, 32'h0},
    '{1'b0, 6'h14, 32'h0, 4'hf, 32'h00005f00},
    '{1'b1, 6'h18, 32'h00010001, 4'hf, 32'h0},
    '{1'b0, 6'h14, 32'h0, 4'hf, 32'h00005f01},
    '{1'b1, 6'h18, 32'hffffffff, 4'h4, 32'h0},
    '{1'b0, 6'h14, 32'h0, 4'hf, 32'h00005f00},
    '{1'b1, 6'h10, 32'hffffffff, 4'hf, 32'h0},
    '{1'b0, 6'h10, 32'h0, 4'hf, 32'h00005f00},
    '{1'b1, 6'h08, 32'h000000e4, 4'hf, 32'h0},
    '{1'b0, 6'h08, 32'h0, 4'hf, 32'h000000e4}};

  gpcr_top dut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_level(pin_level), .pin_analog_mode(pin_analog_mode),
    .very_high_speed_bit(very_high_speed_bit),
    .pad_drive_speed(pad_drive_speed), .pad_speed_class(pad_speed_class),
    .pad_very_high_speed(pad_very_high_speed),
    .pad_pull_select(pad_pull_select), .pad_output_level(pad_output_level),
    .pin_config_frozen(pin_config_frozen));
  gpcr_pin_model u_pins (
    .pad_output_level(pad_output_level), .ext_en(ext_en),
    .ext_val(ext_val), .pin_level(pin_level));
  // a port without the lock and with zero reset values, on the same bus
  gpcr_top #(.IS_PORT_A(1'b0), .HAS_LOCK(1'b0)) dut_b (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(), .avs_waitrequest(),
    .pin_level(pin_level), .pin_analog_mode(pin_analog_mode),
    .very_high_speed_bit(very_high_speed_bit),
    .pad_drive_speed(b_drive), .pad_speed_class(),
    .pad_very_high_speed(), .pad_pull_select(b_pull),
    .pad_output_level(), .pin_config_frozen(b_frozen));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ****************
  // tasks
  // ****************
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // waitrequest is read at each rising edge, before that edge updates it
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      $display("FAIL %0t bus timeout", $time);
      end_sim();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [5:0] a, input logic [31:0] e,
                     input string m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e, m);
  endtask : rdc

  // ****************
  // sequence
  // ****************
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {failures, num_checks} = '0;
    avs_byteenable = 4'h0;
    rst_n = 1'b0;
    pin_analog_mode = 16'h0;
    very_high_speed_bit = 16'hffff;
    {ext_en, ext_val} = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].adr, rows[i].dat, rows[i].be, rd);
      if (!rows[i].wr)
        chk(rd, rows[i].exp, "table read");
    end
    $display("table done");
    repeat (2) @(posedge mclk);
    chk(pad_speed_class, 32'h84, "speed class");
    chk({16'h0, pad_very_high_speed}, 32'h8, "very high speed");
    ext_en <= 16'hffff;
    ext_val <= 16'h0f0f;
    pin_analog_mode <= 16'h0003;
    repeat (4) @(posedge mclk);
    rdc(6'h10, 32'h00000f0c, "input levels");
    $display("pads done");
    // changed lock bits in the third write abort the key, so the read still sees it 0
    bus(1'b1, 6'h1c, 32'h1000f, 4'h7, rd);
    bus(1'b1, 6'h1c, 32'h0000f, 4'h7, rd);
    bus(1'b1, 6'h1c, 32'h10003, 4'h7, rd);
    rdc(6'h1c, 32'h00003, "aborted key");
    chk({16'h0, pin_config_frozen}, 32'h0, "not frozen");
    bus(1'b1, 6'h1c, 32'h1000f, 4'h7, rd);
    bus(1'b1, 6'h1c, 32'h0000f, 4'h7, rd);
    bus(1'b1, 6'h1c, 32'h1000f, 4'h7, rd);
    rdc(6'h1c, 32'h0000f, "key read zero");
    rdc(6'h1c, 32'h1000f, "key read one");
    chk({16'h0, pin_config_frozen}, 32'hf, "frozen pins");
    bus(1'b1, 6'h08, 32'hffffffff, 4'hf, rd);
    rdc(6'h08, 32'hffffffe4, "frozen speed");
    chk(b_drive, 32'hffffffff, "no lock on port b");
    bus(1'b1, 6'h0c, 32'h0, 4'hf, rd);
    rdc(6'h0c, 32'h00000099, "frozen pull");
    bus(1'b1, 6'h1c, 32'h0, 4'h7, rd);
    rdc(6'h1c, 32'h1000f, "lock held");
    chk({16'h0, b_frozen}, 32'h0, "port b never frozen");
    $display("lock done");
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(6'h1c, 32'h0, "lock after reset");
    rdc(6'h08, 32'h0c000000, "speed after reset");
    chk({16'h0, pin_config_frozen}, 32'h0, "freeze cleared");
    chk(b_drive, 32'h0, "port b speed reset");
    chk(b_pull, 32'h0, "port b pull reset");
    $display("reset done");
    end_sim();
  end
endmodule : test_gpcr_top
`default_nettype wire
